// ==== rhs_params.svh ====
`ifndef RHS_PARAMS_SVH
`define RHS_PARAMS_SVH
//------------------------------------------------------------------------------
// Overview of operation
// - Software loads descriptor-two fields at init; reset values are a build parameter.
// - Descriptor two reads on code 13H and writes on code 93H; the code takes writes on index 13H, and 93H is unmapped.
// - Hub status reads on code 14H and writes on code 94H; the code takes writes on index 14H, and 94H is unmapped.
// - Per-port mode: masked ports obey only per-port power commands, others global.
// - In global switching mode the power-control mask is ignored.
// - Mask bit 0 reserved, bit 1 is port one, bit 2 is port two.
// - Removable flag clear means removable device, set means non-removable.
// - Removable bit 0 reserved, bit 1 is port one, bit 2 is port two.
// - Hub status in lower 16 bits, change flags in upper 16 bits.
// - Switching selection 0 powers all ports together, 1 powers individually.
// - Overcurrent change flag sets on indicator change, write 1 clears.
// - Write 1 to bit 16 powers on, bit 0 powers off, unmasked ports.
// - Wakeup enable makes connect change a resume; bit 15 sets, bit 31 clears.
//------------------------------------------------------------------------------

// Register indices (command codes); byte address is four times the index.
`define RHS_IDX_DESC_TWO      8'h13
`define RHS_IDX_HUB_STATUS    8'h14
`define RHS_IDX_IRQ_STATUS    8'h18
`define RHS_IDX_IRQ_ENABLE    8'h19
`define RHS_IDX_IRQ_CLEAR     8'h1A
`define RHS_IDX_CONTROL       8'h1B
`define RHS_IDX_PORT_POWER    8'h1C
`define RHS_WRITE_CODE_BIT    7

// Descriptor two fields.
`define RHS_MASK_LSB          16
`define RHS_REMOVABLE_LSB     0
`define RHS_DESC_FIELD_W      3

// Hub status fields.
`define RHS_GOFF_BIT          0
`define RHS_OVC_BIT           1
`define RHS_WAKE_EN_BIT       15
`define RHS_GON_BIT           16
`define RHS_OVCC_BIT          17
`define RHS_CLR_WAKE_BIT      31

// Control register fields.
`define RHS_CTL_SEL_BIT       0

// Port power command register fields.
`define RHS_PP_SET_LSB        0
`define RHS_PP_CLR_LSB        4

// Interrupt status fields.
`define RHS_IRQ_OVCC_BIT      0
`define RHS_IRQ_RESUME_BIT    1
`define RHS_IRQ_W             2

// Reset values.
`define RHS_STATUS_RESET      32'h00000000
`define RHS_DESC_RESET        3'h0

`endif

// ==== rhs_pkg.sv ====
`default_nettype none
package rhs_pkg;

    // Bus slave phases.
    typedef enum logic [1:0] {
        RHS_IDLE = 2'b00,
        RHS_ACK  = 2'b01
    } rhs_bus_state_type;

    // Power switching selection.
    typedef enum logic {
        RHS_GLOBAL_SWITCH  = 1'b0,
        RHS_PER_PORT_SWITCH = 1'b1
    } rhs_sel_type;

endpackage
`default_nettype wire

// ==== rhs_port_power.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rhs_params.svh"

module rhs_port_power #(
    parameter int PORTS = 2
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Mode and mask.
    input  wire logic             per_port_mode,
    input  wire logic [PORTS:0]   port_power_control_mask,
    // Commands, one-cycle pulses.
    input  wire logic             global_on,
    input  wire logic             global_off,
    input  wire logic [PORTS-1:0] port_on,
    input  wire logic [PORTS-1:0] port_off,
    // Port power state.
    output logic      [PORTS-1:0] port_power
);

    //--------------------------------------------------------------------------
    // Per-port power state
    //--------------------------------------------------------------------------

    // In per-port mode each port follows global or per-port commands according to its mask bit; in global mode all follow global.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_power <= '0;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                if (per_port_mode && port_power_control_mask[p+1]) begin
                    if (port_on[p])
                        port_power[p] <= 1'b1;
                    else if (port_off[p])
                        port_power[p] <= 1'b0;
                end else begin
                    if (global_on)
                        port_power[p] <= 1'b1;
                    else if (global_off)
                        port_power[p] <= 1'b0;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== rhs_root_hub_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rhs_params.svh"

module rhs_root_hub_regs #(
    parameter int         PORTS       = 2,
    parameter logic [2:0] MASK_RESET  = `RHS_DESC_RESET,
    parameter logic [2:0] REMOV_RESET = `RHS_DESC_RESET
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Avalon-MM slave.
    input  wire logic [9:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Hub-side status inputs.
    input  wire logic             global_overcurrent_indicator,
    input  wire logic             connect_status_change,
    input  wire logic             suspended,
    // Hub-side outputs.
    output logic      [PORTS-1:0] port_power,
    output logic                  resume_event,
    output logic                  irq
);

    //--------------------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------------------

    logic [2:0]                port_power_control_mask_reg;
    logic [2:0]                device_removable_flags_reg;
    logic                      remote_wakeup_enable_reg;
    logic                      overcurrent_indicator_change_reg;
    logic                      ovc_prev_reg;
    logic                      power_switching_selection_reg;
    logic [`RHS_IRQ_W-1:0]     irq_status_reg;
    logic [`RHS_IRQ_W-1:0]     irq_enable_reg;
    rhs_pkg::rhs_bus_state_type bus_state_reg;
    logic [31:0]               wr_data;
    logic [7:0]                reg_index;
    logic                      wr_fire;
    logic                      rd_fire;
    logic                      ovc_changed;
    logic                      global_on;
    logic                      global_off;
    logic [PORTS-1:0]          port_on;
    logic [PORTS-1:0]          port_off;
    logic [31:0]               rd_value;

    // Builds the write data with byte enables applied; unenabled lanes are zero.
    function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] be);
        lane_mask = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Tests whether a write hits a given register index.
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    //--------------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer
    //--------------------------------------------------------------------------

    assign reg_index = avs_address[9:2];
    assign wr_data   = lane_mask(avs_writedata, avs_byteenable);
    assign wr_fire   = avs_write && (bus_state_reg == rhs_pkg::RHS_ACK);
    assign rd_fire   = avs_read && (bus_state_reg == rhs_pkg::RHS_ACK);

    // Waitrequest is low only in the acknowledge cycle of a held request.
    assign avs_waitrequest = !(bus_state_reg == rhs_pkg::RHS_ACK);

    // Steps the bus phase; a request is acknowledged on the second cycle.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state_reg <= rhs_pkg::RHS_IDLE;
        end else begin
            unique case (bus_state_reg)
                rhs_pkg::RHS_IDLE: begin
                    if (avs_read || avs_write)
                        bus_state_reg <= rhs_pkg::RHS_ACK;
                end
                rhs_pkg::RHS_ACK: begin
                    bus_state_reg <= rhs_pkg::RHS_IDLE;
                end
                default: begin
                    bus_state_reg <= rhs_pkg::RHS_IDLE;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Read multiplexer
    //--------------------------------------------------------------------------

    // Selects the addressed register; unmapped indices read zero.
    always_comb begin
        rd_value = 32'h00000000;
        unique case (reg_index)
            `RHS_IDX_DESC_TWO: begin
                rd_value[`RHS_MASK_LSB +: 3]      = port_power_control_mask_reg;
                rd_value[`RHS_REMOVABLE_LSB +: 3] = device_removable_flags_reg;
            end
            `RHS_IDX_HUB_STATUS: begin
                rd_value[`RHS_OVC_BIT]     = ovc_prev_reg;
                rd_value[`RHS_WAKE_EN_BIT] = remote_wakeup_enable_reg;
                rd_value[`RHS_OVCC_BIT]    = overcurrent_indicator_change_reg;
            end
            `RHS_IDX_IRQ_STATUS: begin
                rd_value[`RHS_IRQ_W-1:0] = irq_status_reg;
            end
            `RHS_IDX_IRQ_ENABLE: begin
                rd_value[`RHS_IRQ_W-1:0] = irq_enable_reg;
            end
            `RHS_IDX_CONTROL: begin
                rd_value[`RHS_CTL_SEL_BIT] = power_switching_selection_reg;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    // Read data are registered and held until the next read.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            avs_readdata <= 32'h00000000;
        else if (avs_read && bus_state_reg == rhs_pkg::RHS_IDLE)
            avs_readdata <= rd_value;
    end

    //--------------------------------------------------------------------------
    // Descriptor two
    //--------------------------------------------------------------------------

    // Mask and removable flags are loaded by software; bit 0 of each is fixed zero.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_power_control_mask_reg <= MASK_RESET & 3'h6;
            device_removable_flags_reg  <= REMOV_RESET & 3'h6;
        end else if (wr_fire && hit(reg_index, `RHS_IDX_DESC_TWO)) begin
            port_power_control_mask_reg <= wr_data[`RHS_MASK_LSB +: 3] & 3'h6;
            device_removable_flags_reg  <= wr_data[`RHS_REMOVABLE_LSB +: 3] & 3'h6;
        end
    end

    //--------------------------------------------------------------------------
    // Control register: power switching selection
    //--------------------------------------------------------------------------

    // Chooses global or per-port power switching.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            power_switching_selection_reg <= rhs_pkg::RHS_GLOBAL_SWITCH;
        else if (wr_fire && hit(reg_index, `RHS_IDX_CONTROL))
            power_switching_selection_reg <= wr_data[`RHS_CTL_SEL_BIT];
    end

    //--------------------------------------------------------------------------
    // Hub status
    //--------------------------------------------------------------------------

    // Registers the overcurrent level so its changes can be seen.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            ovc_prev_reg <= 1'b0;
        else
            ovc_prev_reg <= global_overcurrent_indicator;
    end

    assign ovc_changed = ovc_prev_reg != global_overcurrent_indicator;

    // Change flag: hardware set wins over a write-one clear.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            overcurrent_indicator_change_reg <= 1'b0;
        else if (ovc_changed)
            overcurrent_indicator_change_reg <= 1'b1;
        else if (wr_fire && hit(reg_index, `RHS_IDX_HUB_STATUS)
                 && wr_data[`RHS_OVCC_BIT])
            overcurrent_indicator_change_reg <= 1'b0;
    end

    // Remote wakeup enable: bit 15 sets, bit 31 clears; clear taken if both.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            remote_wakeup_enable_reg <= 1'b0;
        end else if (wr_fire && hit(reg_index, `RHS_IDX_HUB_STATUS)) begin
            if (wr_data[`RHS_CLR_WAKE_BIT])
                remote_wakeup_enable_reg <= 1'b0;
            else if (wr_data[`RHS_WAKE_EN_BIT])
                remote_wakeup_enable_reg <= 1'b1;
        end
    end

    // A connect change while suspended and enabled is a resume event.
    assign resume_event = remote_wakeup_enable_reg && suspended
                          && connect_status_change;

    // Power commands are write-one pulses; zeros do nothing.
    assign global_on  = wr_fire && hit(reg_index, `RHS_IDX_HUB_STATUS)
                        && wr_data[`RHS_GON_BIT];
    assign global_off = wr_fire && hit(reg_index, `RHS_IDX_HUB_STATUS)
                        && wr_data[`RHS_GOFF_BIT];
    assign port_on    = (wr_fire && hit(reg_index, `RHS_IDX_PORT_POWER))
                        ? wr_data[`RHS_PP_SET_LSB +: PORTS] : '0;
    assign port_off   = (wr_fire && hit(reg_index, `RHS_IDX_PORT_POWER))
                        ? wr_data[`RHS_PP_CLR_LSB +: PORTS] : '0;

    //--------------------------------------------------------------------------
    // Port power switching
    //--------------------------------------------------------------------------

    rhs_port_power #(
        .PORTS                   (PORTS)
    ) u_port_power (
        .core_clk                (core_clk),
        .reset_n                 (reset_n),
        .per_port_mode           (power_switching_selection_reg),
        .port_power_control_mask (port_power_control_mask_reg[PORTS:0]),
        .global_on               (global_on),
        .global_off              (global_off),
        .port_on                 (port_on),
        .port_off                (port_off),
        .port_power              (port_power)
    );

    //--------------------------------------------------------------------------
    // Interrupts
    //--------------------------------------------------------------------------

    // Sticky event bits; a new event wins over a write-one clear.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_reg <= '0;
        end else begin
            for (int i = 0; i < `RHS_IRQ_W; i++) begin
                if ((i == `RHS_IRQ_OVCC_BIT && ovc_changed)
                    || (i == `RHS_IRQ_RESUME_BIT && resume_event))
                    irq_status_reg[i] <= 1'b1;
                else if (wr_fire && hit(reg_index, `RHS_IDX_IRQ_CLEAR) && wr_data[i])
                    irq_status_reg[i] <= 1'b0;
            end
        end
    end

    // Enable register gates the sticky bits onto the interrupt line.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            irq_enable_reg <= '0;
        else if (wr_fire && hit(reg_index, `RHS_IDX_IRQ_ENABLE))
            irq_enable_reg <= wr_data[`RHS_IRQ_W-1:0];
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

endmodule
`default_nettype wire

// ==== rhs_root_hub_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module rhs_root_hub_regs_checker #(
    parameter int PORTS = 2
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Avalon-MM slave.
    input  wire logic [9:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    input  wire logic [31:0]      avs_readdata,
    input  wire logic             avs_waitrequest,
    // Hub side.
    input  wire logic             global_overcurrent_indicator,
    input  wire logic             connect_status_change,
    input  wire logic             suspended,
    input  wire logic [PORTS-1:0] port_power,
    input  wire logic             resume_event,
    input  wire logic             irq
);
    //--------------------------------------------------------------------------
    // Helper logic
    //--------------------------------------------------------------------------
    logic       wr_ack;
    logic       rd_ack;
    logic       wake_reg;
    logic [2:0] since_wr_reg;

    // Acknowledged transfers, seen at the edge where waitrequest is low.
    assign wr_ack = avs_write && !avs_waitrequest;
    assign rd_ack = avs_read && !avs_waitrequest;

    // Shadow of the wake enable; a clear in the same write wins over a set.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_reg <= 1'b0;
        end else if (wr_ack && avs_address == 10'h050) begin
            if (avs_byteenable[3] && avs_writedata[31]) begin
                wake_reg <= 1'b0;
            end else if (avs_byteenable[1] && avs_writedata[15]) begin
                wake_reg <= 1'b1;
            end
        end
    end

    // Cycles since the last acknowledged write, saturating at seven.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            since_wr_reg <= 3'h7;
        end else if (wr_ack) begin
            since_wr_reg <= 3'h0;
        end else if (since_wr_reg != 3'h7) begin
            since_wr_reg <= since_wr_reg + 3'h1;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest;
    endsequence

    AST_ONE_WAIT: assert property (s_req_seen |=> s_ack)
        else $error("Request not acknowledged after one wait cycle.");
    AST_ACK_SINGLE: assert property (s_ack |=> avs_waitrequest)
        else $error("Acknowledge lasted more than one cycle.");
    AST_NO_SPURIOUS_ACK: assert property ((!avs_read && !avs_write) [*2] |-> avs_waitrequest)
        else $error("Acknowledge without a request.");
    AST_HUB_READ_BITS: assert property (rd_ack && avs_address == 10'h050
        |-> (avs_readdata & 32'hFFFD7FFD) == 32'h00000000)
        else $error("Hub status read shows a bit that must read zero.");
    AST_DESC_READ_BITS: assert property (rd_ack && avs_address == 10'h04C
        |-> (avs_readdata & 32'hFFF9FFF9) == 32'h00000000)
        else $error("Descriptor read shows a reserved bit.");
    AST_UNMAPPED_ZERO: assert property (rd_ack && avs_address[9:2] > 8'h1C
        |-> avs_readdata == 32'h00000000)
        else $error("Unmapped read returned nonzero data.");
    AST_RESUME_LEVEL: assert property (resume_event
        == (wake_reg && suspended && connect_status_change))
        else $error("Resume event does not follow wake enable and connect change.");
    AST_POWER_CAUSE: assert property ($changed(port_power) |-> since_wr_reg <= 3'h2)
        else $error("Port power changed without a recent write.");
endmodule

bind rhs_root_hub_regs rhs_root_hub_regs_checker #(.PORTS(PORTS)) u_checker (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .global_overcurrent_indicator(global_overcurrent_indicator),
    .connect_status_change(connect_status_change), .suspended(suspended),
    .port_power(port_power), .resume_event(resume_event), .irq(irq));

`default_nettype wire

// ==== root_hub_descriptor_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module root_hub_descriptor_status_regs_tb;
    //--------------------------------------------------------------------------
    // Signals and instance
    //--------------------------------------------------------------------------
    localparam logic [9:0] A_DESC = 10'h04C, A_HUB = 10'h050, A_IST = 10'h060;
    localparam logic [9:0] A_IEN = 10'h064, A_ICL = 10'h068, A_CTL = 10'h06C;
    localparam logic [9:0] A_PP = 10'h070, A_BAD = 10'h3FC;
    logic        core_clk;
    logic        reset_n;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        overcurrent;
    logic        conn_change;
    logic        suspended;
    logic [1:0]  port_power;
    logic        resume_event;
    logic        irq;
    int          bad_count;
    int          n_tests;
    int          cyc;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [1:0]  pp_exp;
    logic        mode_sel;
    logic [2:0]  msk;

    rhs_root_hub_regs #(.PORTS(2), .MASK_RESET(3'h7), .REMOV_RESET(3'h5)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .global_overcurrent_indicator(overcurrent),
        .connect_status_change(conn_change), .suspended(suspended),
        .port_power(port_power), .resume_event(resume_event), .irq(irq));

    // Clock at 40 MHz.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Cuts a hung run short.
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected port power after one command.
    function automatic logic [1:0] pwr_model(input logic [1:0] pp, input logic sel,
        input logic [2:0] m, input logic gon, input logic goff,
        input logic [1:0] pon, input logic [1:0] poff);
        logic [1:0] g;
        logic [1:0] r;
        g = sel ? ~m[2:1] : 2'b11;
        r = pp;
        if (goff) r = r & ~g;
        if (gon) r = r | g;
        if (sel) r = (r & ~(poff & m[2:1])) | (pon & m[2:1]);
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Samples waitrequest at each rising edge and returns on the acknowledge edge.
    task automatic bus_wait();
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    endtask

    task automatic bus_write(input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        bus_wait();
        rd = avs_readdata;
        avs_read <= 1'b0;
        check(rd, exp);
    endtask

    task automatic set_mode(input logic sel, input logic [2:0] m);
        mode_sel = sel;
        msk = m & 3'h6;
        bus_write(A_CTL, {31'h0, sel});
        bus_write(A_DESC, {13'h0, msk, 16'h0});
        rd_chk(A_CTL, {31'h0, sel});
    endtask

    task automatic pwr(input logic gon, input logic goff, input logic [1:0] pon,
        input logic [1:0] poff);
        pp_exp = pwr_model(pp_exp, mode_sel, msk, gon, goff, pon, poff);
        if (gon || goff) bus_write(A_HUB, {15'h0, gon, 15'h0, goff});
        else bus_write(A_PP, {26'h0, poff, 2'b00, pon});
        repeat (3) @(posedge core_clk);
        check({30'h0, port_power}, {30'h0, pp_exp});
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        {reset_n, avs_read, avs_write, overcurrent, conn_change, suspended} = 6'h00;
        avs_address = 10'h000;
        avs_writedata = 32'h00000000;
        {bad_count, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
        {seed, pp_exp, mode_sel, msk} = {32'hF4A5, 2'b00, 1'b0, 3'h0};
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(A_HUB, 32'h00000000);
        rd_chk(A_DESC, 32'h00060004);
        bus_write(A_BAD, 32'hFFFFFFFF);
        rd_chk(A_BAD, 32'h00000000);
        bus_write(A_DESC, 32'hFFFFFFFF);
        rd_chk(A_DESC, 32'h00060006);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            bus_write(A_DESC, seed);
            rd_chk(A_DESC, seed & 32'h00060006);
        end
        bus_write(A_HUB, 32'h00008000);
        rd_chk(A_HUB, 32'h00008000);
        suspended <= 1'b1;
        conn_change <= 1'b1;
        repeat (2) @(posedge core_clk);
        check({31'h0, resume_event}, 32'h00000001);
        bus_write(A_HUB, 32'h80008000);
        rd_chk(A_HUB, 32'h00000000);
        check({31'h0, resume_event}, 32'h00000000);
        {suspended, conn_change} <= 2'b00;
        bus_write(A_ICL, 32'h00000003);
        bus_write(A_IEN, 32'h00000001);
        irq_chk(1'b0);
        overcurrent <= 1'b1;
        irq_chk(1'b1);
        rd_chk(A_HUB, 32'h00020002);
        rd_chk(A_IST, 32'h00000001);
        bus_write(A_HUB, 32'h00000002);
        rd_chk(A_HUB, 32'h00020002);
        bus_write(A_HUB, 32'h00020000);
        rd_chk(A_HUB, 32'h00000002);
        bus_write(A_ICL, 32'h00000001);
        irq_chk(1'b0);
        bus_write(A_IEN, 32'h00000000);
        overcurrent <= 1'b0;
        irq_chk(1'b0);
        rd_chk(A_HUB, 32'h00020000);
        bus_write(A_IEN, 32'h00000001);
        irq_chk(1'b1);
        bus_write(A_ICL, 32'h00000001);
        bus_write(A_HUB, 32'h00020000);
        irq_chk(1'b0);
        set_mode(1'b0, 3'h6);
        pwr(1'b1, 1'b0, 2'b00, 2'b00);
        pwr(1'b0, 1'b1, 2'b00, 2'b00);
        pwr(1'b1, 1'b1, 2'b00, 2'b00);
        set_mode(1'b1, 3'h2);
        pwr(1'b0, 1'b1, 2'b00, 2'b00);
        pwr(1'b0, 1'b0, 2'b10, 2'b00);
        pwr(1'b0, 1'b0, 2'b00, 2'b01);
        pwr(1'b0, 1'b0, 2'b01, 2'b00);
        pwr(1'b1, 1'b0, 2'b00, 2'b00);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            if (seed[3:0] == 4'h0) set_mode(seed[4], seed[7:5]);
            if (!mode_sel || seed[8]) pwr(seed[9], seed[10], 2'b00, 2'b00);
            else pwr(1'b0, 1'b0, seed[12:11], seed[14:13] & ~seed[12:11]);
        end
        give_verdict();
    end
endmodule

`default_nettype wire
